// File: core/siae_map.vh
// Action codes, per-input parameter layout and timing constants for the input evaluator.
`ifndef SIAE_MAP_VH
`define SIAE_MAP_VH
`define SIAE_ACT_W 4
`define SIAE_ACT_NONE 4'h0
`define SIAE_ACT_TRIP_NORST 4'h1
`define SIAE_ACT_TRIP_AUTO 4'h2
`define SIAE_ACT_END_CW 4'h3
`define SIAE_ACT_END_CCW 4'h4
`define SIAE_ACT_GRP_WARN 4'h5
`define SIAE_ACT_MANUAL 4'h6
`define SIAE_ACT_EMERG 4'h7
`define SIAE_ACT_RUN_CW 4'h8
`define SIAE_ACT_RUN_CCW 4'h9
`define SIAE_ACT_QSTOP 4'hA
`define SIAE_ACT_TRIP_RESET 4'hB
`define SIAE_NUM_IN 4
`define SIAE_TIME_W 8
`define SIAE_TICK_US 1000
`define SIAE_CLK_MHZ 40
`define SIAE_TICK_CYC (`SIAE_TICK_US * `SIAE_CLK_MHZ)
`define SIAE_TICK_CNT_W 16
`define SIAE_TICK_LAST 16'h9C3F
`endif

// File: core/siae_input_cond.v
// One input channel: debounce, pulse extension, polarity and retention.
`timescale 1ns/1ps
`default_nettype none
module siae_input_cond (
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  input wire tick,
  input wire raw_in,
  input wire [7:0] debounce_ms,
  input wire [7:0] extend_ms,
  input wire nc_level,
  input wire retentive,
  input wire clear_latch,
  output reg stable_ff,
  output reg reported_ff,
  output wire active,
  output wire active_edge
);
  reg [7:0] deb_cnt_ff;
  reg [7:0] ext_cnt_ff;
  reg lvl_prev_ff;
  reg latch_ff;
  wire lvl;
  // Polarity applies to the action only; the reported bit always shows voltage.
  assign lvl = stable_ff ^ nc_level;
  assign active_edge = lvl & ~lvl_prev_ff;
  assign active = retentive ? latch_ff : lvl;
  always @(posedge core_clk) begin
    if (rst) begin
      deb_cnt_ff <= 8'h00;
      ext_cnt_ff <= 8'h00;
      stable_ff <= 1'b0;
      reported_ff <= 1'b0;
      lvl_prev_ff <= 1'b0;
      latch_ff <= 1'b0;
    end else if (clk_en) begin
      if (raw_in == stable_ff) begin
        deb_cnt_ff <= 8'h00;
      end else if (deb_cnt_ff >= debounce_ms) begin
        stable_ff <= raw_in;
        deb_cnt_ff <= 8'h00;
      end else if (tick) begin
        deb_cnt_ff <= deb_cnt_ff + 8'h01;
      end
      if (stable_ff) begin
        ext_cnt_ff <= extend_ms;
        reported_ff <= 1'b1;
      end else if (ext_cnt_ff != 8'h00) begin
        if (tick) begin
          ext_cnt_ff <= ext_cnt_ff - 8'h01;
        end
      end else begin
        reported_ff <= 1'b0;
      end
      lvl_prev_ff <= lvl;
      // A new active edge wins over a clear in the same cycle.
      if (active_edge) begin
        latch_ff <= 1'b1;
      end else if (clear_latch) begin
        latch_ff <= 1'b0;
      end
    end
  end
endmodule // siae_input_cond
`default_nettype wire

// File: core/siae_evaluator.v
// Top of the starter input action evaluator.
`timescale 1ns/1ps
`default_nettype none
`include "siae_map.vh"
module siae_evaluator (
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  input wire [3:0] digital_input,
  input wire [15:0] cfg_action,
  input wire [3:0] cfg_nc_level,
  input wire [3:0] cfg_retentive,
  input wire [31:0] cfg_debounce_ms,
  input wire [31:0] cfg_extend_ms,
  input wire cfg_load,
  input wire bus_cmd_cw,
  input wire bus_cmd_ccw,
  input wire bus_cmd_brake,
  input wire trip_ack,
  input wire quick_stop_disable,
  input wire internal_trip,
  input wire self_protect_trip,
  output reg [3:0] process_image_in_ff,
  output reg motor_cw_ff,
  output reg motor_ccw_ff,
  output reg brake_ff,
  output reg input_trip_ff,
  output reg group_fault_ff,
  output reg group_warning_ff,
  output reg manual_local_ff,
  output reg param_reject_ff,
  output reg end_cw_block_ff,
  output reg end_ccw_block_ff
);
  // Live parameter set; only a consistent set is adopted on cfg_load.
  reg [15:0] act_ff;
  reg [3:0] nc_ff;
  reg [3:0] ret_ff;
  reg [31:0] deb_ff;
  reg [31:0] ext_ff;
  reg [15:0] tick_cnt_ff;
  reg tick_ff;
  reg latched_trip_ff;
  reg end_brake_hold_ff;
  reg qstop_latch_ff;
  reg [3:0] prev_nc_trip_ff;
  wire [3:0] stable;
  wire [3:0] reported;
  wire [3:0] active;
  wire [3:0] edge_act;
  wire [3:0] clr;
  wire [3:0] is_trip_norst;
  wire [3:0] is_trip_auto;
  wire [3:0] is_end_cw;
  wire [3:0] is_end_ccw;
  wire [3:0] is_warn;
  wire [3:0] is_manual;
  wire [3:0] is_emerg;
  wire [3:0] is_run_cw;
  wire [3:0] is_run_ccw;
  wire [3:0] is_qstop;
  wire [3:0] is_reset;
  wire [3:0] cfg_bad_pol;
  wire [3:0] cfg_ret_run;
  wire [3:0] cfg_guard;
  wire [3:0] polchg_trip;
  wire trip_reset_ev;
  wire cfg_ok;
  genvar gi;
  generate
    for (gi = 0; gi < `SIAE_NUM_IN; gi = gi + 1) begin : g_in
      wire [3:0] a;
      wire [3:0] ca;
      wire ret_ok;
      assign a = act_ff[gi*4 +: 4];
      assign ca = cfg_action[gi*4 +: 4];
      // Trip, end-position, manual and emergency actions always follow the input level.
      assign ret_ok = ret_ff[gi] & ((a == `SIAE_ACT_GRP_WARN) | (a == `SIAE_ACT_RUN_CW) |
        (a == `SIAE_ACT_RUN_CCW) | (a == `SIAE_ACT_QSTOP));
      assign is_trip_norst[gi] = active[gi] & (a == `SIAE_ACT_TRIP_NORST);
      assign is_trip_auto[gi] = active[gi] & (a == `SIAE_ACT_TRIP_AUTO);
      assign is_end_cw[gi] = active[gi] & (a == `SIAE_ACT_END_CW);
      assign is_end_ccw[gi] = active[gi] & (a == `SIAE_ACT_END_CCW);
      assign is_warn[gi] = active[gi] & (a == `SIAE_ACT_GRP_WARN);
      assign is_manual[gi] = active[gi] & (a == `SIAE_ACT_MANUAL);
      assign is_emerg[gi] = active[gi] & (a == `SIAE_ACT_EMERG);
      assign is_run_cw[gi] = active[gi] & (a == `SIAE_ACT_RUN_CW);
      assign is_run_ccw[gi] = active[gi] & (a == `SIAE_ACT_RUN_CCW);
      assign is_qstop[gi] = edge_act[gi] & (a == `SIAE_ACT_QSTOP);
      assign is_reset[gi] = edge_act[gi] & (a == `SIAE_ACT_TRIP_RESET);
      // Polarity restriction checked on the incoming set.
      assign cfg_bad_pol[gi] = cfg_nc_level[gi] & ((ca == `SIAE_ACT_EMERG) |
        (ca == `SIAE_ACT_RUN_CW) | (ca == `SIAE_ACT_RUN_CCW) |
        (ca == `SIAE_ACT_TRIP_RESET));
      assign cfg_ret_run[gi] = cfg_retentive[gi] &
        ((ca == `SIAE_ACT_RUN_CW) | (ca == `SIAE_ACT_RUN_CCW));
      assign cfg_guard[gi] = (ca == `SIAE_ACT_TRIP_NORST) | (ca == `SIAE_ACT_TRIP_AUTO) |
        (ca == `SIAE_ACT_END_CW) | (ca == `SIAE_ACT_END_CCW) | (ca == `SIAE_ACT_QSTOP);
      // NC-to-NO switch on a no-restart trip input that is open.
      assign polchg_trip[gi] = cfg_load & cfg_ok & nc_ff[gi] & ~cfg_nc_level[gi] &
        (ca == `SIAE_ACT_TRIP_NORST);
      // Retentive warnings clear on trip reset; retentive runs on quick stop or fault.
      assign clr[gi] = (a == `SIAE_ACT_GRP_WARN) ? trip_reset_ev :
        (((a == `SIAE_ACT_RUN_CW) | (a == `SIAE_ACT_RUN_CCW)) ?
        (qstop_latch_ff | group_fault_ff) : 1'b0);
      siae_input_cond u_cond (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .tick(tick_ff),
        .raw_in(digital_input[gi]),
        .debounce_ms(deb_ff[gi*8 +: 8]),
        .extend_ms(ext_ff[gi*8 +: 8]),
        .nc_level(nc_ff[gi]),
        .retentive(ret_ok),
        .clear_latch(clr[gi]),
        .stable_ff(stable[gi]),
        .reported_ff(reported[gi]),
        .active(active[gi]),
        .active_edge(edge_act[gi])
      );
    end
  endgenerate
  assign trip_reset_ev = (|is_reset) | trip_ack;
  assign cfg_ok = ~(|cfg_bad_pol) & ~((|cfg_ret_run) & ~(|cfg_guard));
  // All per-input effects are ORed below; an emergency-start input masks the trip inputs, and quick-stop, end and opposite run inputs block a run.
  wire trip_now;
  wire run_cw_req;
  wire run_ccw_req;
  wire brake_req;
  wire trip_block;
  wire manual_any;
  assign trip_now = (|is_trip_norst) | (|is_trip_auto) | (|is_end_cw) | (|is_end_ccw);
  assign manual_any = (|is_manual) | (manual_local_ff & ((|is_run_cw) | (|is_run_ccw)));
  assign run_cw_req = manual_any ? (|is_run_cw) : bus_cmd_cw;
  assign run_ccw_req = manual_any ? (|is_run_ccw) : bus_cmd_ccw;
  assign brake_req = manual_any ? ((|is_run_cw) | (|is_run_ccw)) : bus_cmd_brake;
  // Emergency start overrides internal trips but never self-protection.
  assign trip_block = self_protect_trip | ((trip_now | latched_trip_ff | internal_trip |
    input_trip_ff) & ~(|is_emerg));
  always @(posedge core_clk) begin
    if (rst) begin
      act_ff <= 16'h0000;
      nc_ff <= 4'h0;
      ret_ff <= 4'h0;
      deb_ff <= 32'h0000_0000;
      ext_ff <= 32'h0000_0000;
      tick_cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
      process_image_in_ff <= 4'h0;
      motor_cw_ff <= 1'b0;
      motor_ccw_ff <= 1'b0;
      brake_ff <= 1'b0;
      input_trip_ff <= 1'b0;
      group_fault_ff <= 1'b0;
      group_warning_ff <= 1'b0;
      manual_local_ff <= 1'b0;
      param_reject_ff <= 1'b0;
      end_cw_block_ff <= 1'b0;
      end_ccw_block_ff <= 1'b0;
      latched_trip_ff <= 1'b0;
      end_brake_hold_ff <= 1'b0;
      qstop_latch_ff <= 1'b0;
      prev_nc_trip_ff <= 4'h0;
    end else if (clk_en) begin
      // Millisecond time base shared by all debounce and extension counters.
      tick_ff <= (tick_cnt_ff == `SIAE_TICK_LAST);
      tick_cnt_ff <= (tick_cnt_ff == `SIAE_TICK_LAST) ? 16'h0000 : tick_cnt_ff + 16'h0001;
      process_image_in_ff <= reported;
      if (cfg_load) begin
        if (cfg_ok) begin
          act_ff <= cfg_action;
          nc_ff <= cfg_nc_level;
          ret_ff <= cfg_retentive;
          deb_ff <= cfg_debounce_ms;
          ext_ff <= cfg_extend_ms;
          param_reject_ff <= 1'b0;
        end else begin
          param_reject_ff <= 1'b1;
        end
      end
      prev_nc_trip_ff <= polchg_trip;
      // Trip-without-restart holds until acknowledged after the cause is gone.
      // The polarity-change check looks only at the input that was switched.
      if ((|is_trip_norst) | (|(prev_nc_trip_ff & ~stable))) begin
        latched_trip_ff <= 1'b1;
        input_trip_ff <= 1'b1;
      end else if (trip_reset_ev) begin
        latched_trip_ff <= 1'b0;
        input_trip_ff <= 1'b0;
      end
      // Auto-restart trips drop with their cause, so the fault follows the level.
      group_fault_ff <= trip_now | latched_trip_ff;
      if (|is_warn) begin
        group_warning_ff <= 1'b1;
      end else begin
        group_warning_ff <= 1'b0;
      end
      manual_local_ff <= manual_any;
      if (|is_qstop) begin
        qstop_latch_ff <= 1'b1;
      end else if (quick_stop_disable | (~run_cw_req & ~run_ccw_req)) begin
        qstop_latch_ff <= 1'b0;
      end
      if (|is_end_cw) begin
        end_cw_block_ff <= 1'b1;
        end_brake_hold_ff <= 1'b1;
      end else if (run_ccw_req) begin
        end_cw_block_ff <= 1'b0;
      end
      if (|is_end_ccw) begin
        end_ccw_block_ff <= 1'b1;
        end_brake_hold_ff <= 1'b1;
      end else if (run_cw_req) begin
        end_ccw_block_ff <= 1'b0;
      end
      if (~((|is_end_cw) | (|is_end_ccw)) & ~brake_req & ~run_cw_req & ~run_ccw_req) begin
        end_brake_hold_ff <= 1'b0;
      end
      motor_cw_ff <= run_cw_req & ~run_ccw_req & ~trip_block & ~qstop_latch_ff &
        ~(|is_qstop) & ~end_cw_block_ff;
      motor_ccw_ff <= run_ccw_req & ~run_cw_req & ~trip_block & ~qstop_latch_ff &
        ~(|is_qstop) & ~end_ccw_block_ff;
      brake_ff <= brake_req & ~trip_block & ~qstop_latch_ff & ~(|is_qstop) &
        ~end_brake_hold_ff;
    end
  end
endmodule // siae_evaluator
`default_nettype wire

// File: bench/siae_eval_assertions.sv
// Concurrent checks on the ports of the starter input action evaluator.
`timescale 1ns/1ps
`default_nettype none
`include "siae_map.vh"
module siae_eval_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [15:0] cfg_action,
  input wire logic [3:0] cfg_nc_level,
  input wire logic [3:0] cfg_retentive,
  input wire logic cfg_load,
  input wire logic self_protect_trip,
  input wire logic [3:0] process_image_in_ff,
  input wire logic motor_cw_ff,
  input wire logic motor_ccw_ff,
  input wire logic group_fault_ff,
  input wire logic param_reject_ff,
  input wire logic end_cw_block_ff,
  input wire logic end_ccw_block_ff
);
  logic nc_bad, ret_run, has_trip;
  logic [3:0] act;
  // Consistency of the offered set is judged over all four inputs, as the device does.
  always_comb begin
    nc_bad = 1'b0;
    ret_run = 1'b0;
    has_trip = 1'b0;
    act = 4'h0;
    for (int i = 0; i < 4; i++) begin
      act = cfg_action[4*i+:4];
      nc_bad |= cfg_nc_level[i] && (act == `SIAE_ACT_EMERG || act == `SIAE_ACT_RUN_CW ||
        act == `SIAE_ACT_RUN_CCW || act == `SIAE_ACT_TRIP_RESET);
      ret_run |= cfg_retentive[i] && (act == `SIAE_ACT_RUN_CW || act == `SIAE_ACT_RUN_CCW);
      has_trip |= (act >= `SIAE_ACT_TRIP_NORST && act <= `SIAE_ACT_END_CCW) ||
        act == `SIAE_ACT_QSTOP;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_load; clk_en && cfg_load; endsequence
  sequence s_cw_held; end_cw_block_ff [*2]; endsequence
  sequence s_ccw_held; end_ccw_block_ff [*2]; endsequence
  property p_reset; $fell(rst) |-> process_image_in_ff == 4'h0 && !group_fault_ff; endproperty
  property p_rej_nc; s_load ##0 nc_bad |=> param_reject_ff; endproperty
  property p_rej_ret; s_load ##0 (ret_run && !has_trip) |=> param_reject_ff; endproperty
  property p_accept; s_load ##0 !(nc_bad || (ret_run && !has_trip)) |=> !param_reject_ff; endproperty
  property p_hold; !(clk_en && cfg_load) |=> $stable(param_reject_ff); endproperty
  property p_selfprot; clk_en && self_protect_trip |=> !motor_cw_ff && !motor_ccw_ff; endproperty
  property p_end_cw; s_cw_held |-> !motor_cw_ff; endproperty
  property p_end_ccw; s_ccw_held |-> !motor_ccw_ff; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  a_rej_nc: assert property (p_rej_nc) else $error("closed contact set accepted");
  a_rej_ret: assert property (p_rej_ret) else $error("latched run set accepted");
  a_accept: assert property (p_accept) else $error("consistent set refused");
  a_hold: assert property (p_hold) else $error("reject flag moved without load");
  a_selfprot: assert property (p_selfprot) else $error("motor on under self trip");
  a_end_cw: assert property (p_end_cw) else $error("cw run while cw end blocked");
  a_end_ccw: assert property (p_end_ccw) else $error("ccw run while ccw end blocked");
endmodule // siae_eval_chk
bind siae_evaluator siae_eval_chk chk (.core_clk, .rst, .clk_en, .cfg_action, .cfg_nc_level,
  .cfg_retentive, .cfg_load, .self_protect_trip, .process_image_in_ff, .motor_cw_ff,
  .motor_ccw_ff, .group_fault_ff, .param_reject_ff, .end_cw_block_ff, .end_ccw_block_ff);
`default_nettype wire

// File: bench/siae_bus_ctrl.sv
// Fieldbus controller model: sends run commands and captures the process image.
`timescale 1ns/1ps
`default_nettype none
module siae_bus_ctrl (
  input wire logic core_clk,
  input wire logic [3:0] want,
  input wire logic [3:0] process_image_in_ff,
  output logic bus_cmd_cw = 1'b0,
  output logic bus_cmd_ccw = 1'b0,
  output logic bus_cmd_brake,
  output logic trip_ack = 1'b0,
  output logic quick_stop_disable = 1'b0,
  output logic [3:0] pi_seen
);
  // The brake command is never issued, so brake paths are only reached through run inputs.
  assign bus_cmd_brake = 1'b0;
  // Commands refresh once per bus cycle, which adds one clock of latency on purpose.
  always @(posedge core_clk) begin
    {quick_stop_disable, trip_ack, bus_cmd_ccw, bus_cmd_cw} <= want;
    pi_seen <= process_image_in_ff;
  end
endmodule // siae_bus_ctrl
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the starter input action evaluator.
`timescale 1ns/1ps
`default_nettype none
`include "siae_map.vh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module tb_top;
  logic core_clk, rst, clk_en, cfg_load, internal_trip, self_protect_trip, bus_cmd_cw;
  logic bus_cmd_ccw, bus_cmd_brake, trip_ack, quick_stop_disable, motor_cw_ff, motor_ccw_ff;
  logic brake_ff, input_trip_ff, group_fault_ff, group_warning_ff, manual_local_ff;
  logic param_reject_ff, end_cw_block_ff, end_ccw_block_ff;
  logic [3:0] digital_input, cfg_nc_level, cfg_retentive, want, pi_seen, process_image_in_ff;
  logic [15:0] cfg_action;
  logic [31:0] cfg_debounce_ms, cfg_extend_ms, deb_v, ext_v;
  int err_count = 0, checks = 0;
  siae_evaluator uut (.core_clk, .rst, .clk_en, .digital_input, .cfg_action, .cfg_nc_level,
    .cfg_retentive, .cfg_debounce_ms, .cfg_extend_ms, .cfg_load, .bus_cmd_cw, .bus_cmd_ccw,
    .bus_cmd_brake, .trip_ack, .quick_stop_disable, .internal_trip, .self_protect_trip,
    .process_image_in_ff, .motor_cw_ff, .motor_ccw_ff, .brake_ff, .input_trip_ff,
    .group_fault_ff, .group_warning_ff, .manual_local_ff, .param_reject_ff, .end_cw_block_ff,
    .end_ccw_block_ff);
  siae_bus_ctrl fb (.core_clk, .want, .process_image_in_ff, .bus_cmd_cw, .bus_cmd_ccw,
    .bus_cmd_brake, .trip_ack, .quick_stop_disable, .pi_seen);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Control bits are {self trip, internal trip, disable quick stop, ack, ccw, cw}.
  task automatic drv(input logic [3:0] d, input logic [5:0] c);
    @(posedge core_clk);
    {digital_input, self_protect_trip, internal_trip, want} <= {d, c};
    w(5);
  endtask
  task automatic cfg(input logic [15:0] a, input logic [3:0] nc, input logic [3:0] rt,
      input logic rej);
    @(posedge core_clk);
    {cfg_action, cfg_nc_level, cfg_retentive, cfg_load} <= {a, nc, rt, 1'b1};
    {cfg_debounce_ms, cfg_extend_ms} <= {deb_v, ext_v};
    @(posedge core_clk);
    cfg_load <= 1'b0;
    w(1);
    `CHK("param_reject", rej, param_reject_ff)
  endtask
  task automatic t_params();
    logic [3:0] no_only [4] = '{`SIAE_ACT_EMERG, `SIAE_ACT_RUN_CW, `SIAE_ACT_RUN_CCW,
      `SIAE_ACT_TRIP_RESET};
    foreach (no_only[i]) cfg({12'h000, no_only[i]}, 4'h1, 4'h0, 1'b1);
    cfg(16'h0008, 4'h0, 4'h1, 1'b1);
    cfg(16'h0018, 4'h0, 4'h1, 1'b0);
  endtask
  task automatic t_trip();
    cfg(16'h0002, 4'h1, 4'h0, 1'b0);
    drv(4'h1, 6'h01);
    `CHK("seen", 4'h1, pi_seen)
    `CHK("cw", 1'b1, motor_cw_ff)
    drv(4'h0, 6'h01);
    `CHK("cw", 1'b0, motor_cw_ff)
    `CHK("image", 4'h0, process_image_in_ff)
    drv(4'h1, 6'h01);
    `CHK("cw", 1'b1, motor_cw_ff)
    drv(4'h0, 6'h01);
    cfg(16'h0001, 4'h1, 4'h0, 1'b0);
    // Holding the acknowledge makes the check below depend on the polarity-change trip alone.
    drv(4'h0, 6'h04);
    cfg(16'h0001, 4'h0, 4'h0, 1'b0);
    `CHK("in_trip", 1'b1, input_trip_ff)
    drv(4'h0, 6'h05);
    `CHK("fault", 1'b0, group_fault_ff)
    drv(4'h1, 6'h01);
    drv(4'h0, 6'h01);
    `CHK("fault", 1'b1, group_fault_ff)
    drv(4'h0, 6'h05);
    `CHK("cw", 1'b1, motor_cw_ff)
  endtask
  task automatic t_modes();
    cfg(16'h0050, 4'h0, 4'h2, 1'b0);
    drv(4'h2, 6'h01);
    `CHK("warn", 1'b1, group_warning_ff)
    `CHK("cw", 1'b1, motor_cw_ff)
    drv(4'h0, 6'h01);
    `CHK("warn", 1'b1, group_warning_ff)
    drv(4'h0, 6'h05);
    `CHK("warn", 1'b0, group_warning_ff)
    cfg(16'h0086, 4'h0, 4'h0, 1'b0);
    drv(4'h1, 6'h01);
    `CHK("cw", 1'b0, motor_cw_ff)
    drv(4'h3, 6'h00);
    `CHK("cw", 1'b1, motor_cw_ff)
    `CHK("brake", 1'b1, brake_ff)
    drv(4'h2, 6'h00);
    `CHK("manual", 1'b1, manual_local_ff)
    drv(4'h0, 6'h00);
    `CHK("manual", 1'b0, manual_local_ff)
  endtask
  task automatic t_run();
    cfg(16'h0007, 4'h0, 4'h0, 1'b0);
    drv(4'h0, 6'h11);
    `CHK("cw", 1'b0, motor_cw_ff)
    drv(4'h1, 6'h11);
    `CHK("cw", 1'b1, motor_cw_ff)
    drv(4'h1, 6'h31);
    `CHK("cw", 1'b0, motor_cw_ff)
    drv(4'h0, 6'h04);
    cfg(16'h0003, 4'h0, 4'h0, 1'b0);
    drv(4'h1, 6'h01);
    `CHK("cw", 1'b0, motor_cw_ff)
    `CHK("end_cw", 1'b1, end_cw_block_ff)
    drv(4'h0, 6'h01);
    `CHK("cw", 1'b0, motor_cw_ff)
    drv(4'h0, 6'h02);
    `CHK("ccw", 1'b1, motor_ccw_ff)
    cfg(16'h0004, 4'h0, 4'h0, 1'b0);
    drv(4'h1, 6'h02);
    `CHK("end_ccw", 1'b1, end_ccw_block_ff)
    drv(4'h0, 6'h02);
    `CHK("ccw", 1'b0, motor_ccw_ff)
    cfg(16'h000A, 4'h0, 4'h1, 1'b0);
    drv(4'h0, 6'h01);
    drv(4'h1, 6'h01);
    `CHK("cw", 1'b0, motor_cw_ff)
    `CHK("fault", 1'b0, group_fault_ff)
    drv(4'h1, 6'h09);
    drv(4'h1, 6'h01);
    `CHK("cw", 1'b1, motor_cw_ff)
  endtask
  task automatic t_ctl();
    @(posedge core_clk);
    clk_en <= 1'b0;
    drv(4'h0, 6'h00);
    `CHK("frozen", 4'h1, process_image_in_ff)
    `CHK("frozen", 1'b1, motor_cw_ff)
    @(posedge core_clk);
    clk_en <= 1'b1;
    w(5);
    `CHK("image", 4'h0, process_image_in_ff)
    `CHK("cw", 1'b0, motor_cw_ff)
    drv(4'h0, 6'h01);
    @(posedge core_clk);
    rst <= 1'b1;
    w(2);
    `CHK("cw", 1'b0, motor_cw_ff)
    @(posedge core_clk);
    rst <= 1'b0;
    w(2);
    `CHK("cw", 1'b1, motor_cw_ff)
  endtask
  task automatic t_time();
    ext_v = 32'h0001_0000;
    cfg(16'h0000, 4'h0, 4'h0, 1'b0);
    drv(4'h4, 6'h00);
    drv(4'h0, 6'h00);
    w(100);
    `CHK("stretch", 4'h4, process_image_in_ff)
    w(40000);
    `CHK("stretch", 4'h0, process_image_in_ff)
    {ext_v, deb_v} = {32'h0000_0000, 32'h0100_0000};
    cfg(16'h0000, 4'h0, 4'h0, 1'b0);
    drv(4'h8, 6'h00);
    w(100);
    `CHK("debounce", 4'h0, process_image_in_ff)
    w(40000);
    `CHK("debounce", 4'h8, process_image_in_ff)
  endtask
  initial begin
    {rst, clk_en, cfg_load, digital_input, want, self_protect_trip, internal_trip} = 13'h1800;
    {cfg_action, cfg_nc_level, cfg_retentive, cfg_debounce_ms, cfg_extend_ms} = '0;
    {deb_v, ext_v} = '0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    w(2);
    `CHK("image", 4'h0, process_image_in_ff)
    t_params();
    t_trip();
    t_modes();
    t_run();
    t_ctl();
    t_time();
    stop_test();
  end
  initial begin
    #3_000_000;
    err_count++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
